// File: verification/lpe_error_handler_asserts.sv
// Port-level checker for the link protocol error handler
`timescale 1ns/1ps
module lpe_error_handler_asserts #(
  parameter BIDIR = 1
) (
  input logic        MCLK,
  input logic        RESET,
  input logic        ACK_REQUEST,
  input logic        ACK_VALID,
  input logic [23:0] ACK_WORD,
  input logic        RX_BYTE_VALID,
  input logic        RX_WRITE_EN,
  input logic        RX_DISCARD,
  input logic [2:0]  LP_STATE,
  input logic        S_AXI_AWVALID,
  input logic        S_AXI_AWREADY,
  input logic        S_AXI_WVALID,
  input logic        S_AXI_WREADY,
  input logic [1:0]  S_AXI_BRESP,
  input logic        S_AXI_BVALID,
  input logic        S_AXI_BREADY,
  input logic        S_AXI_ARVALID,
  input logic        S_AXI_ARREADY,
  input logic [31:0] S_AXI_RDATA,
  input logic        S_AXI_RVALID,
  input logic        S_AXI_RREADY
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  sequence wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence hold_left;
    LP_STATE == 3'h7 ##1 LP_STATE != 3'h7;
  endsequence
  sequence saw10_left;
    LP_STATE == 3'h1 ##1 LP_STATE != 3'h1;
  endsequence
  a_ack_reply: assert property (ACK_REQUEST |=> ACK_VALID == (BIDIR != 0))
    else $error("ack reply wrong");
  a_ack_type: assert property (ACK_VALID |-> ACK_WORD[7:0] == 8'h02)
    else $error("ack data type wrong");
  a_ack_cause: assert property (!ACK_REQUEST |=> !ACK_VALID)
    else $error("ack without request");
  a_byte_gate: assert property (RX_BYTE_VALID |-> RX_WRITE_EN)
    else $error("byte forwarded while writes off");
  a_discard_once: assert property (RX_DISCARD |=> !RX_DISCARD)
    else $error("discard pulse too long");
  a_hold_exit: assert property (hold_left |-> LP_STATE == 3'h0)
    else $error("hold left to wrong state");
  a_spur_exit: assert property (saw10_left |-> LP_STATE inside {3'h0, 3'h3, 3'h7})
    else $error("request state left wrongly");
  a_bresp_after: assert property (wr_taken |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  a_bresp_holds: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_read_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_rdata_holds: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
endmodule // lpe_error_handler_asserts

bind lpe_error_handler lpe_error_handler_asserts #(.BIDIR(BIDIR)) chk (.MCLK, .RESET, .ACK_REQUEST,
  .ACK_VALID, .ACK_WORD, .RX_BYTE_VALID, .RX_WRITE_EN, .RX_DISCARD, .LP_STATE, .S_AXI_AWVALID,
  .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID, .S_AXI_RREADY);

// File: verification/lpe_error_handler_tb.sv
// Self-checking bench for the link protocol error handler
`timescale 1ns/1ps
`include "lpe_map.vh"
module lpe_error_handler_tb;
  logic        MCLK, RESET, LINK_CLK, HS_ACTIVE, HS_DATA, LP_DP, LP_DN, ACK_REQUEST, IRQ;
  logic [7:0]  RX_BYTE, lastb;
  logic        RX_BYTE_VALID, RX_WRITE_EN, RX_DISCARD, ACK_VALID, we_seen;
  logic [23:0] ACK_WORD;
  logic [2:0]  LP_STATE;
  logic [4:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rv;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rr;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  int          mismatches, checked, cyc, nbyte, ndisc;
  logic [7:0]  known [5] = '{8'h1E, 8'h62, 8'h5D, 8'h21, 8'hA0};

  lpe_error_handler #(.BIDIR(1)) dut (.MCLK, .RESET, .LINK_CLK, .HS_ACTIVE, .HS_DATA, .LP_DP, .LP_DN,
    .ACK_REQUEST, .RX_BYTE, .RX_BYTE_VALID, .RX_WRITE_EN, .RX_DISCARD, .ACK_VALID, .ACK_WORD, .LP_STATE,
    .IRQ, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID,
    .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
  lpe_host_link host (.link_clk(LINK_CLK), .hs_active(HS_ACTIVE), .hs_data(HS_DATA), .lp_dp(LP_DP),
    .lp_dn(LP_DN));

  initial
  begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end

  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (RX_BYTE_VALID)
      lastb = RX_BYTE;
    nbyte = nbyte + RX_BYTE_VALID;
    ndisc = ndisc + RX_DISCARD;
    we_seen = we_seen | RX_WRITE_EN;
    if (cyc == 20000)
    begin
      mismatches++;
      finish_test;
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    // Each channel drops at the edge that takes it; the response is taken where bvalid is seen
    do
    begin
      @(posedge MCLK);
      if (S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
    end
    while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do
    begin
      @(posedge MCLK);
      if (S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
    end
    while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask

  task automatic stat(input logic [31:0] e);
    repeat (8) @(posedge MCLK);
    rd(`LPE_ADDR_STATUS, rv, rr);
    cmp(rv, e);
  endtask

  task automatic ack_chk(input logic [23:0] e);
    ACK_REQUEST <= 1'b1;
    @(posedge MCLK);
    ACK_REQUEST <= 1'b0;
    #1;
    cmp({7'h00, ACK_VALID, ACK_WORD}, {8'h01, e});
  endtask

  task automatic burst(input logic [7:0] lead, input logic [31:0] d, input int nb);
    wr(`LPE_ADDR_STATUS, 32'h0000001F, rr);
    nbyte = 0;
    ndisc = 0;
    we_seen = 1'b0;
    host.hs_burst(lead, d, nb);
    repeat (8) @(posedge MCLK);
  endtask

  task t_regs;
    stat(32'h0);
    rd(`LPE_ADDR_CTRL, rv, rr);
    cmp(rv, 32'h1);
    rd(5'h14, rv, rr);
    cmp({30'h0, rr}, {30'h0, `LPE_RESP_SLVERR});
    wr(`LPE_ADDR_REPORT, 32'h0, rr);
    cmp({30'h0, rr}, {30'h0, `LPE_RESP_SLVERR});
    $display("test regs done");
  endtask

  task t_hs;
    burst(8'hBF, 32'h3CA5, 16);
    cmp(nbyte, 0);
    cmp({31'h0, we_seen}, 32'h0);
    stat(32'h01);
    ack_chk(24'h000202);
    stat(32'h01);
    burst(8'hB9, 32'h3CA5, 16);
    cmp({nbyte[23:0], lastb}, 32'h0000023C);
    cmp({ndisc[30:0], we_seen}, 32'h1);
    stat(32'h0);
    burst(8'hB8, 32'h0A5, 12);
    cmp({nbyte[15:0], ndisc[15:0]}, 32'h00010001);
    stat(32'h02);
    ack_chk(24'h000402);
    $display("test high speed done");
  endtask

  task t_lp;
    wr(`LPE_ADDR_STATUS, 32'h0000001F, rr);
    host.esc(8'h55, 0, 0);
    cmp(LP_STATE, 32'h7);
    stat(32'h0);
    host.lp(`LPE_LS_STOP);
    cmp(LP_STATE, 32'h0);
    stat(32'h04);
    wr(`LPE_ADDR_STATUS, 32'h0000001F, rr);
    foreach (known[i])
    begin
      host.esc(known[i], 0, 0);
      host.lp(`LPE_LS_STOP);
    end
    host.esc(`LPE_CMD_LPDT, 32'hA55A, 16);
    host.lp(`LPE_LS_STOP);
    stat(32'h0);
    host.esc(`LPE_CMD_LPDT, 32'h5A5, 12);
    host.lp(`LPE_LS_STOP);
    stat(32'h08);
    $display("test low power done");
  endtask

  task t_false;
    wr(`LPE_ADDR_MASK, 32'h00000010, rr);
    host.lp(`LPE_LS_ZERO_ONE);
    host.lp(`LPE_LS_ZERO);
    host.lp(`LPE_LS_STOP);
    stat(32'h08);
    host.lp(`LPE_LS_ONE_ZERO);
    host.lp(`LPE_LS_STOP);
    stat(32'h18);
    cmp({LP_STATE, IRQ}, 32'h1);
    wr(`LPE_ADDR_MASK, 32'h0, rr);
    repeat (2) @(posedge MCLK);
    cmp(IRQ, 32'h0);
    wr(`LPE_ADDR_MASK, 32'h00000010, rr);
    wr(`LPE_ADDR_STATUS, 32'h00000010, rr);
    stat(32'h08);
    cmp(IRQ, 32'h0);
    wr(`LPE_ADDR_CTRL, 32'h0, rr);
    host.lp(`LPE_LS_ZERO_ONE);
    host.lp(`LPE_LS_STOP);
    stat(32'h08);
    $display("test spurious control done");
  endtask

  task finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    {RESET, ACK_REQUEST, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} = 5'h10;
    {S_AXI_ARVALID, S_AXI_RREADY, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = '0;
    S_AXI_WSTRB = 4'hF;
    {mismatches, checked, cyc, nbyte, ndisc} = '0;
    repeat (5) @(posedge MCLK);
    RESET <= 1'b0;
    @(posedge MCLK);
    t_regs;
    t_hs;
    t_lp;
    t_false;
    finish_test;
  end
endmodule // lpe_error_handler_tb

// File: verification/lpe_host_link.sv
// Behavioural host end of the serial link
`timescale 1ns/1ps
module lpe_host_link (
  output logic link_clk,
  output logic hs_active,
  output logic hs_data,
  output logic lp_dp,
  output logic lp_dn
);
  initial
  begin
    link_clk = 1'b0;
    hs_active = 1'b0;
    hs_data = 1'b0;
    lp_dp = 1'b1;
    lp_dn = 1'b1;
  end
  // Clock runs only inside a burst; 3 ns offset keeps it off the system edge
  task automatic hs_burst(input logic [7:0] lead, input logic [31:0] d, input int nb);
    logic [39:0] bits;
    bits = {d, lead};
    #3;
    hs_active = 1'b1;
    for (int i = 0; i < nb + 8; i++)
    begin
      hs_data = bits[i];
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
    hs_active = 1'b0;
    // Released line: show the inverse so a stale value is never trusted
    hs_data = ~hs_data;
  endtask
  task automatic lp(input logic [1:0] s);
    {lp_dp, lp_dn} = s;
    #60;
  endtask
  // Escape entry, then spaced-one bits LSB first; Stop is left to the caller
  task automatic esc(input logic [7:0] cmd, input logic [31:0] d, input int nb);
    logic [39:0] bits;
    bits = {d, cmd};
    lp(2'b10);
    lp(2'b00);
    lp(2'b01);
    lp(2'b00);
    for (int i = 0; i < nb + 8; i++)
    begin
      lp(bits[i] ? 2'b10 : 2'b01);
      lp(2'b00);
    end
  endtask
endmodule // lpe_host_link

// File: verilog/lpe_error_handler.v
// Receive-side low-level protocol error detection, storage and reporting
`timescale 1ns/1ps
`include "lpe_map.vh"

// Notes on behaviour
// - A corrupt high-speed leader raises start_sync_fault, captured in status.
// - Bytes of a burst with a corrupt leader are withheld.
// - Acknowledge after start_sync_fault carries data type 02h with its bit set.
// - After start_sync_fault no command is acted on and writes stay disabled.
// - A burst ending off a byte boundary raises end_boundary_fault.
// - Acknowledge after end_boundary_fault carries its bit in the report bytes.
// - On end_boundary_fault the burst is discarded where still possible.
// - An unrecognised escape entry command raises escape_entry_fault.
// - Both ends detect bad escape entries; only the peripheral reports them.
// - After escape_entry_fault hold until Stop, then return to low-power receive.
// - Ignore the escape transmission; set escape_entry_fault once back in receive.
// - Low-power data ending off a byte boundary raises lowpower_boundary_fault.
// - Both ends detect low-power boundary faults; only the peripheral reports.
// - After that fault return to receive until Stop, discard, set its bit.
// - A request state followed directly by Stop raises spurious_control_fault.
// - On that fault ignore the request, wait for Stop, set its bit.
// - Every detected error is kept as a stored status bit.
// - A unidirectional peripheral does not report errors.
module lpe_error_handler #(
  parameter BIDIR = 1
) (
  input  wire        MCLK,
  input  wire        RESET,
  input  wire        LINK_CLK,
  input  wire        HS_ACTIVE,
  input  wire        HS_DATA,
  input  wire        LP_DP,
  input  wire        LP_DN,
  input  wire        ACK_REQUEST,
  output reg  [7:0]  RX_BYTE,
  output reg         RX_BYTE_VALID,
  output reg         RX_WRITE_EN,
  output reg         RX_DISCARD,
  output reg         ACK_VALID,
  output reg  [23:0] ACK_WORD,
  output reg  [2:0]  LP_STATE,
  output reg         IRQ,
  input  wire [4:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [4:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY
);

  localparam ST_STOP   = 3'd0;
  localparam ST_REQ10  = 3'd1;
  localparam ST_REQ01  = 3'd2;
  localparam ST_ESC1   = 3'd3;
  localparam ST_ESC2   = 3'd4;
  localparam ST_CMD    = 3'd5;
  localparam ST_LPDT   = 3'd6;
  localparam ST_HOLD   = 3'd7;

  // Two-stage synchronisers; only the second stage is read
  reg  [4:0] sync_a;
  reg  [4:0] sync_b;
  reg        clk_prev;
  reg        act_prev;
  reg  [1:0] ls_prev;

  wire       link_clk_s = sync_b[0];
  wire       hs_act_s   = sync_b[1];
  wire       hs_data_s  = sync_b[2];
  wire [1:0] line_s     = sync_b[4:3];
  wire       link_rise  = link_clk_s & ~clk_prev;
  wire       ls_change  = line_s != ls_prev;

  reg  [31:0] status;
  reg  [31:0] mask;
  reg  [31:0] ctrl;
  wire        enable = ctrl[`LPE_CTRL_ENABLE];

  reg  [2:0] hs_cnt;
  reg  [7:0] hs_shift;
  reg        hs_lead;
  reg        hs_bad;
  reg        ev_sync;
  reg        ev_end;

  reg  [2:0] lp_cnt;
  reg  [7:0] lp_shift;
  reg        esc_pend;
  reg        ev_esc;
  reg        ev_lpb;
  reg        ev_false;
  reg  [2:0] next_lp_state;

  always @(posedge MCLK)
  begin
    if (RESET)
    begin
      sync_a   <= 5'h18;
      sync_b   <= 5'h18;
      clk_prev <= 1'b0;
      act_prev <= 1'b0;
      ls_prev  <= `LPE_LS_STOP;
    end
    else
    begin
      sync_a   <= {LP_DP, LP_DN, HS_DATA, HS_ACTIVE, LINK_CLK};
      sync_b   <= sync_a;
      clk_prev <= link_clk_s;
      act_prev <= hs_act_s;
      ls_prev  <= line_s;
    end
  end

  // Distance of the received leader from the expected pattern
  wire [7:0] lead_in  = {hs_data_s, hs_shift[7:1]};
  wire [7:0] lead_err = lead_in ^ `LPE_HS_LEADER;
  reg  [3:0] lead_dist;
  integer    i;
  always @*
  begin
    lead_dist = 4'h0;
    for (i = 0; i < 8; i = i + 1)
      lead_dist = lead_dist + {3'h0, lead_err[i]};
  end

  // High-speed receiver: bits enter LSB first on link clock rising edges
  always @(posedge MCLK)
  begin
    if (RESET)
    begin
      hs_cnt        <= 3'h0;
      hs_shift      <= 8'h00;
      hs_lead       <= 1'b0;
      hs_bad        <= 1'b0;
      ev_sync       <= 1'b0;
      ev_end        <= 1'b0;
      RX_BYTE       <= 8'h00;
      RX_BYTE_VALID <= 1'b0;
      RX_WRITE_EN   <= 1'b0;
    end
    else
    begin
      ev_sync       <= 1'b0;
      ev_end        <= 1'b0;
      RX_BYTE_VALID <= 1'b0;
      if (hs_act_s & ~act_prev)
      begin
        hs_cnt  <= 3'h0;
        hs_lead <= 1'b1;
        hs_bad  <= 1'b0;
      end
      else if (hs_act_s & link_rise)
      begin
        hs_shift <= lead_in;
        hs_cnt   <= hs_cnt + 3'h1;
        if (hs_cnt == 3'h7)
        begin
          if (hs_lead)
          begin
            hs_lead <= 1'b0;
            if (lead_dist > `LPE_HS_TOLERANCE)
            begin
              hs_bad  <= 1'b1;
              ev_sync <= enable;
            end
            else
              RX_WRITE_EN <= 1'b1;
          end
          else if (!hs_bad)
          begin
            RX_BYTE       <= lead_in;
            RX_BYTE_VALID <= 1'b1;
          end
        end
      end
      else if (~hs_act_s & act_prev)
      begin
        RX_WRITE_EN <= 1'b0;
        if (hs_cnt != 3'h0 && !hs_lead)
          ev_end <= enable;
      end
    end
  end

  // Low-power receive control; bits are spaced-one coded after each zero state
  always @*
  begin
    next_lp_state = LP_STATE;
    case (LP_STATE)
      ST_STOP:
        if (line_s == `LPE_LS_ONE_ZERO)
          next_lp_state = ST_REQ10;
        else if (line_s == `LPE_LS_ZERO_ONE)
          next_lp_state = ST_REQ01;
      ST_REQ10:
        if (line_s == `LPE_LS_STOP)
          next_lp_state = ST_STOP;
        else if (line_s == `LPE_LS_ZERO)
          next_lp_state = ST_ESC1;
        else if (line_s == `LPE_LS_ZERO_ONE)
          next_lp_state = ST_HOLD;
      ST_REQ01:
        if (line_s == `LPE_LS_STOP)
          next_lp_state = ST_STOP;
        else if (line_s != `LPE_LS_ZERO_ONE)
          next_lp_state = ST_HOLD;
      ST_ESC1:
        if (line_s == `LPE_LS_ZERO_ONE)
          next_lp_state = ST_ESC2;
        else if (line_s != `LPE_LS_ZERO)
          next_lp_state = ST_HOLD;
      ST_ESC2:
        if (line_s == `LPE_LS_ZERO)
          next_lp_state = ST_CMD;
        else if (line_s != `LPE_LS_ZERO_ONE)
          next_lp_state = ST_HOLD;
      ST_CMD:
        if (line_s == `LPE_LS_STOP)
          next_lp_state = ST_STOP;
        else if (ls_change && ls_prev == `LPE_LS_ZERO && lp_cnt == 3'h7)
          next_lp_state = ({line_s[1], lp_shift[7:1]} == `LPE_CMD_LPDT) ? ST_LPDT : ST_HOLD;
      ST_LPDT:
        if (line_s == `LPE_LS_STOP)
          next_lp_state = ST_STOP;
      ST_HOLD:
        if (line_s == `LPE_LS_STOP)
          next_lp_state = ST_STOP;
      default:
        next_lp_state = ST_STOP;
    endcase
  end

  wire [7:0] cmd_in = {line_s[1], lp_shift[7:1]};
  wire       cmd_known = cmd_in == `LPE_CMD_LPDT || cmd_in == `LPE_CMD_ULPS ||
                         cmd_in == `LPE_CMD_TRIG_A || cmd_in == `LPE_CMD_TRIG_B ||
                         cmd_in == `LPE_CMD_TRIG_C || cmd_in == `LPE_CMD_TRIG_D;
  wire       lp_bit = ls_change && ls_prev == `LPE_LS_ZERO && line_s != `LPE_LS_STOP &&
                      line_s != `LPE_LS_ZERO;

  always @(posedge MCLK)
  begin
    if (RESET)
    begin
      LP_STATE <= ST_STOP;
      lp_cnt   <= 3'h0;
      lp_shift <= 8'h00;
      esc_pend <= 1'b0;
      ev_esc   <= 1'b0;
      ev_lpb   <= 1'b0;
      ev_false <= 1'b0;
    end
    else
    begin
      LP_STATE <= next_lp_state;
      ev_esc   <= 1'b0;
      ev_lpb   <= 1'b0;
      ev_false <= 1'b0;
      if (LP_STATE == ST_ESC2)
        lp_cnt <= 3'h0;
      else if (lp_bit && (LP_STATE == ST_CMD || LP_STATE == ST_LPDT))
      begin
        lp_shift <= cmd_in;
        lp_cnt   <= lp_cnt + 3'h1;
        // An unknown entry command is held until Stop; a truncated one is flagged at Stop
        if (LP_STATE == ST_CMD && lp_cnt == 3'h7 && !cmd_known)
          esc_pend <= 1'b1;
      end
      if ((LP_STATE == ST_REQ10 || LP_STATE == ST_REQ01) && line_s == `LPE_LS_STOP)
        ev_false <= enable;
      if (LP_STATE == ST_CMD && line_s == `LPE_LS_STOP)
        ev_esc <= enable;
      if (LP_STATE == ST_HOLD && line_s == `LPE_LS_STOP && esc_pend)
      begin
        esc_pend <= 1'b0;
        ev_esc   <= enable;
      end
      if (LP_STATE == ST_LPDT && line_s == `LPE_LS_STOP && lp_cnt != 3'h0)
        ev_lpb <= enable;
    end
  end

  // Sticky status, mask and interrupt
  reg         aw_hold;
  reg         w_hold;
  reg  [4:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire [31:0] events = {27'h0, ev_false, ev_lpb, ev_esc, ev_end, ev_sync};
  wire        wr_fire = aw_hold & w_hold & ~S_AXI_BVALID;
  wire [31:0] err_mask = (32'h1 << `LPE_NUM_ERR) - 32'h1;
  wire [31:0] w_lanes = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] w_eff = w_data & w_lanes;

  always @(posedge MCLK)
  begin
    if (RESET)
    begin
      status <= 32'h0;
      mask   <= 32'h0;
      ctrl   <= `LPE_CTRL_RESET;
      IRQ    <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle
      if (wr_fire && aw_addr == `LPE_ADDR_STATUS)
        status <= ((status & ~w_eff) | events) & err_mask;
      else
        status <= (status | events) & err_mask;
      if (wr_fire && aw_addr == `LPE_ADDR_MASK)
        mask <= ((mask & ~w_lanes) | w_eff) & err_mask;
      if (wr_fire && aw_addr == `LPE_ADDR_CTRL)
        ctrl <= ((ctrl & ~w_lanes) | w_eff) & `LPE_CTRL_RESET;
      IRQ <= |(status & mask);
    end
  end

  // Error report bytes; a unidirectional peripheral never answers
  wire [15:0] report = (16'h1 << `LPE_RPT_SYNC)  & {16{status[`LPE_BIT_SYNC]}}
                     | (16'h1 << `LPE_RPT_END)   & {16{status[`LPE_BIT_END]}}
                     | (16'h1 << `LPE_RPT_ESC)   & {16{status[`LPE_BIT_ESC]}}
                     | (16'h1 << `LPE_RPT_LPB)   & {16{status[`LPE_BIT_LPB]}}
                     | (16'h1 << `LPE_RPT_FALSE) & {16{status[`LPE_BIT_FALSE]}};

  always @(posedge MCLK)
  begin
    if (RESET)
    begin
      ACK_VALID  <= 1'b0;
      ACK_WORD   <= 24'h0;
      RX_DISCARD <= 1'b0;
    end
    else
    begin
      ACK_VALID  <= ACK_REQUEST & (BIDIR != 0);
      if (ACK_REQUEST)
        ACK_WORD <= {report, `LPE_DT_ACK_ERR};
      RX_DISCARD <= ev_sync | ev_end | ev_lpb | ev_esc;
    end
  end

  // AXI4-Lite slave; address and data may arrive in either order
  always @(posedge MCLK)
  begin
    if (RESET)
    begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `LPE_RESP_OKAY;
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 5'h0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold       <= 1'b1;
        aw_addr       <= {S_AXI_AWADDR[4:2], 2'b00};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold       <= 1'b1;
        w_data       <= S_AXI_WDATA;
        w_strb       <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (aw_addr == `LPE_ADDR_STATUS || aw_addr == `LPE_ADDR_MASK ||
                         aw_addr == `LPE_ADDR_CTRL) ? `LPE_RESP_OKAY : `LPE_RESP_SLVERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
      begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always @(posedge MCLK)
  begin
    if (RESET)
    begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0;
      S_AXI_RRESP   <= `LPE_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= `LPE_RESP_OKAY;
      case ({S_AXI_ARADDR[4:2], 2'b00})
        `LPE_ADDR_STATUS: S_AXI_RDATA <= status;
        `LPE_ADDR_MASK:   S_AXI_RDATA <= mask;
        `LPE_ADDR_CTRL:   S_AXI_RDATA <= ctrl;
        `LPE_ADDR_REPORT: S_AXI_RDATA <= {8'h00, report, `LPE_DT_ACK_ERR};
        `LPE_ADDR_LINE:   S_AXI_RDATA <= {24'h0, RX_WRITE_EN, hs_bad, hs_act_s, LP_STATE, line_s};
        default:
        begin
          S_AXI_RDATA <= 32'h0;
          S_AXI_RRESP <= `LPE_RESP_SLVERR;
        end
      endcase
    end
    else if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

endmodule // lpe_error_handler

// File: verilog/lpe_map.vh
// Register map, field positions and line codes of the link protocol error handler
`ifndef LPE_MAP_VH
`define LPE_MAP_VH

// Register byte addresses
`define LPE_ADDR_STATUS    5'h00
`define LPE_ADDR_MASK      5'h04
`define LPE_ADDR_CTRL      5'h08
`define LPE_ADDR_REPORT    5'h0C
`define LPE_ADDR_LINE      5'h10

// Status and mask bit positions
`define LPE_BIT_SYNC       0
`define LPE_BIT_END        1
`define LPE_BIT_ESC        2
`define LPE_BIT_LPB        3
`define LPE_BIT_FALSE      4
`define LPE_NUM_ERR        5

// Control register
`define LPE_CTRL_ENABLE    0
`define LPE_CTRL_RESET     32'h0000_0001

// Error report field inside the acknowledge word
`define LPE_RPT_SYNC       1
`define LPE_RPT_END        2
`define LPE_RPT_ESC        3
`define LPE_RPT_LPB        4
`define LPE_RPT_FALSE      5
`define LPE_DT_ACK_ERR     8'h02

// High-speed leader byte and the bit errors it tolerates
`define LPE_HS_LEADER      8'hB8
`define LPE_HS_TOLERANCE   4'h1

// Low-power line states {DP, DN}
`define LPE_LS_STOP        2'b11
`define LPE_LS_ONE_ZERO    2'b10
`define LPE_LS_ZERO_ONE    2'b01
`define LPE_LS_ZERO        2'b00

// Escape entry commands
`define LPE_CMD_LPDT       8'hE1
`define LPE_CMD_ULPS       8'h1E
`define LPE_CMD_TRIG_A     8'h62
`define LPE_CMD_TRIG_B     8'h5D
`define LPE_CMD_TRIG_C     8'h21
`define LPE_CMD_TRIG_D     8'hA0

// AXI responses
`define LPE_RESP_OKAY      2'b00
`define LPE_RESP_SLVERR    2'b10

`endif
